// file: rtl/psm_pkg.sv
// shared constants and types of the power saving mode controller
package psm_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_CKCTL = 3'h0;
    localparam logic [2:0] ADDR_WDCMP = 3'h1;
    localparam logic [2:0] ADDR_STAT = 3'h2;
    localparam logic [2:0] ADDR_BITCNT = 3'h3;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CK_WAKE_BIT = 6;
    localparam int CK_RCWD_BIT = 5;
    localparam int CK_WDRST_BIT = 4;
    localparam int CK_PSEL_HI = 2;
    localparam int WD_CLR_BIT = 7;
    localparam int WD_CMP_HI = 6;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_STATE_LO = 1;

    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [7:0] CKCTL_RST = 8'h00;
    localparam logic [7:0] WDCMP_RST = 8'h7F;
    localparam int PRESC_W = 11;
    localparam int PSEL_BASE = 4;
    localparam logic [7:0] BIT_MAX = 8'hFF;
    localparam logic [7:0] BIT_START = 8'h00;
    localparam logic [6:0] WD_START = 7'h00;

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PSM_RUN,
        PSM_STOP,
        PSM_WAKE_TMR,
        PSM_RC_WATCHDOG,
        PSM_STABILISE
    } psm_state_t;

endpackage : psm_pkg

// file: rtl/psm_in_sync.sv
// two-flop synchroniser with rising edge pulse for pin inputs
`timescale 1ns/1ps
`default_nettype none
module psm_in_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pins
    input wire logic [W-1:0] pin_in,
    // synchronised outputs
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } psm_sync_t;

    psm_sync_t s_r;
    psm_sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // edge logic reads only the second and third stages
    assign level = s_r.s2;
    assign rise = s_r.s2 & ~s_r.s3;

endmodule : psm_in_sync
`default_nettype wire

// file: rtl/psm_ctrl.sv
// power saving mode controller: mode entry, wake-up and stabilisation
// Summary of operation
// - stop instruction enters mode by select bits: 00 stop, 1X wake timer, 01 RC watchdog.
// - a pending interrupt flag at stop makes the core carry on running.
// - stop mode halts oscillator and clocked functions, keeps RAM, registers, ports.
// - program counter holds the address after stop during low power.
// - stop mode ends only by reset or either external interrupt.
// - wake-up vectors when master enable set, else resumes after stop.
// - external wake from stop restarts interval timer at zero, resumes on overflow.
// - wake timer mode keeps oscillator, divide-by-2048 prescaler and first timer.
// - wake timer mode ends by reset, first timer overflow or external interrupt.
// - wake timer exit by interrupt or overflow resumes with no wait.
// - RC watchdog mode stops main oscillator, runs RC oscillator, holds state.
// - RC watchdog mode ends by reset, interrupt or watchdog; interrupt exit stabilises.
// - watchdog wake with interrupts on: reset select 1 resets, else irq routine.
// - watchdog flag raised when 7-bit counter equals low compare bits.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [psm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [psm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [psm_pkg::DATA_W-1:0] reg_rdata,
    // core and interrupt logic
    input wire logic stop_exec,
    input wire logic irq_pending,
    input wire logic int_master_en,
    input wire logic watchdog_irq_enable,
    input wire logic first_timer_ovf,
    // pins
    input wire logic ext_irq_zero,
    input wire logic ext_irq_one,
    input wire logic rc_osc_clk,
    // clock gating and status
    output logic main_osc_run,
    output logic rc_osc_run,
    output logic cpu_clk_en,
    output logic prescaler_en,
    output logic first_timer_en,
    output logic presc_2048_tick,
    output logic pc_hold,
    // wake-up results
    output logic take_vector,
    output logic resume_next,
    output logic wdt_irq_req,
    output logic int_reset_req
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        psm_pkg::psm_state_t state;
        logic [7:0] ckctl;
        logic [7:0] wdcmp;
        logic [psm_pkg::PRESC_W-1:0] presc;
        logic [7:0] bit_cnt;
        logic [6:0] wd_cnt;
        logic wd_flag;
        logic wd_wake;
        logic [7:0] rdata;
        logic vec;
        logic resume;
        logic wd_irq;
        logic rst_req;
    } psm_ctrl_t;

    psm_ctrl_t s_r;
    psm_ctrl_t s_nxt;

    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic ext_edge;
    logic rc_tick;
    logic presc_tick;
    logic bit_tick;
    logic bit_ovf;
    logic wd_match;
    logic stop_taken;

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    psm_in_sync #(
        .W(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in({rc_osc_clk, ext_irq_one, ext_irq_zero}),
        .level(pin_level),
        .rise(pin_rise)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // true when the low (sel+base) prescaler bits are all ones
    function automatic logic psm_div_tick(input logic [psm_pkg::PRESC_W-1:0] cnt, input logic [2:0] sel);
        logic [psm_pkg::PRESC_W-1:0] mask;
        mask = ~({psm_pkg::PRESC_W{1'b1}} << (sel + psm_pkg::PSEL_BASE));
        return &(cnt | ~mask);
    endfunction : psm_div_tick

    function automatic logic psm_is_run(input psm_pkg::psm_state_t st);
        return st == psm_pkg::PSM_RUN;
    endfunction : psm_is_run

    // edges seen on the free-running sampler regardless of core clock
    assign ext_edge = pin_rise[0] | pin_rise[1];
    assign rc_tick = pin_rise[2];
    assign presc_tick = prescaler_en & psm_div_tick(s_r.presc, s_r.ckctl[psm_pkg::CK_PSEL_HI:0]);
    assign presc_2048_tick = prescaler_en & (&s_r.presc);
    // interval timer runs from the RC clock in RC watchdog mode, else from the prescaler tick
    assign bit_tick = (s_r.state == psm_pkg::PSM_RC_WATCHDOG) ? rc_tick : presc_tick;
    assign bit_ovf = bit_tick & (s_r.bit_cnt == psm_pkg::BIT_MAX);
    assign wd_match = s_r.wd_cnt == s_r.wdcmp[psm_pkg::WD_CMP_HI:0];
    assign stop_taken = psm_is_run(s_r.state) & stop_exec & ~irq_pending;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.vec = 1'b0;
        s_nxt.resume = 1'b0;
        s_nxt.wd_irq = 1'b0;
        s_nxt.rst_req = 1'b0;
        s_nxt.rdata = '0;

        // prescaler and interval timer
        if (prescaler_en) begin
            s_nxt.presc = s_r.presc + 1'b1;
        end
        if (bit_tick) begin
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
        end

        // watchdog counter clocked by interval timer overflow
        if (bit_ovf && s_r.state != psm_pkg::PSM_STABILISE) begin
            s_nxt.wd_cnt = wd_match ? psm_pkg::WD_START : s_r.wd_cnt + 1'b1;
        end
        // register writes; whole-byte only
        if (reg_wr) begin
            case (reg_addr)
                psm_pkg::ADDR_CKCTL: begin
                    s_nxt.ckctl = reg_wdata;
                end
                psm_pkg::ADDR_WDCMP: begin
                    s_nxt.wdcmp = reg_wdata & ~(8'h01 << psm_pkg::WD_CLR_BIT);
                    if (reg_wdata[psm_pkg::WD_CLR_BIT]) begin
                        s_nxt.wd_cnt = psm_pkg::WD_START;
                    end
                end
                psm_pkg::ADDR_STAT: begin
                    // write one clears
                    if (reg_wdata[psm_pkg::STAT_FLAG_BIT]) begin
                        s_nxt.wd_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // set after the clear, so a same-cycle set wins
        if (bit_ovf && wd_match && s_r.state != psm_pkg::PSM_STABILISE) begin
            s_nxt.wd_flag = 1'b1;
        end

        // register reads, data in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                psm_pkg::ADDR_CKCTL: s_nxt.rdata = s_r.ckctl;
                psm_pkg::ADDR_WDCMP: s_nxt.rdata = s_r.wdcmp;
                psm_pkg::ADDR_STAT: s_nxt.rdata = {4'h0, s_r.state, s_r.wd_flag};
                psm_pkg::ADDR_BITCNT: s_nxt.rdata = s_r.bit_cnt;
                default: s_nxt.rdata = '0;
            endcase
        end

        // mode sequencing
        case (s_r.state)
            psm_pkg::PSM_RUN: begin
                if (stop_taken) begin
                    if (s_r.ckctl[psm_pkg::CK_WAKE_BIT]) begin
                        s_nxt.state = psm_pkg::PSM_WAKE_TMR;
                        s_nxt.presc = '0;
                    end else if (s_r.ckctl[psm_pkg::CK_RCWD_BIT]) begin
                        s_nxt.state = psm_pkg::PSM_RC_WATCHDOG;
                    end else begin
                        s_nxt.state = psm_pkg::PSM_STOP;
                    end
                end
            end
            psm_pkg::PSM_STOP: begin
                if (ext_edge) begin
                    s_nxt.state = psm_pkg::PSM_STABILISE;
                    s_nxt.bit_cnt = psm_pkg::BIT_START;
                    s_nxt.presc = '0;
                    s_nxt.wd_wake = 1'b0;
                end
            end
            psm_pkg::PSM_WAKE_TMR: begin
                if (ext_edge || first_timer_ovf) begin
                    s_nxt.state = psm_pkg::PSM_RUN;
                    s_nxt.vec = int_master_en;
                    s_nxt.resume = ~int_master_en;
                end
            end
            psm_pkg::PSM_RC_WATCHDOG: begin
                if (s_r.wd_flag && int_master_en && s_r.ckctl[psm_pkg::CK_WDRST_BIT]) begin
                    s_nxt.state = psm_pkg::PSM_RUN;
                    s_nxt.rst_req = 1'b1;
                end else if (ext_edge || s_r.wd_flag) begin
                    s_nxt.state = psm_pkg::PSM_STABILISE;
                    s_nxt.bit_cnt = psm_pkg::BIT_START;
                    s_nxt.presc = '0;
                    s_nxt.wd_wake = ~ext_edge;
                end
            end
            psm_pkg::PSM_STABILISE: begin
                if (bit_ovf) begin
                    s_nxt.state = psm_pkg::PSM_RUN;
                    if (int_master_en && s_r.wd_wake) begin
                        s_nxt.wd_irq = watchdog_irq_enable;
                        s_nxt.vec = watchdog_irq_enable;
                        s_nxt.resume = ~watchdog_irq_enable;
                    end else begin
                        s_nxt.vec = int_master_en;
                        s_nxt.resume = ~int_master_en;
                    end
                end
            end
            default: begin
                s_nxt.state = psm_pkg::PSM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r.state <= psm_pkg::PSM_RUN;
            s_r.ckctl <= psm_pkg::CKCTL_RST;
            s_r.wdcmp <= psm_pkg::WDCMP_RST;
            s_r.presc <= '0;
            s_r.bit_cnt <= psm_pkg::BIT_START;
            s_r.wd_cnt <= psm_pkg::WD_START;
            s_r.wd_flag <= 1'b0;
            s_r.wd_wake <= 1'b0;
            s_r.rdata <= '0;
            s_r.vec <= 1'b0;
            s_r.resume <= 1'b0;
            s_r.wd_irq <= 1'b0;
            s_r.rst_req <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // oscillator off in stop and RC modes; RC oscillator only in RC mode
    assign main_osc_run = s_r.state != psm_pkg::PSM_STOP && s_r.state != psm_pkg::PSM_RC_WATCHDOG;
    assign rc_osc_run = s_r.state == psm_pkg::PSM_RC_WATCHDOG;
    assign cpu_clk_en = psm_is_run(s_r.state);
    // prescaler and first timer alive in wake timer mode
    assign prescaler_en = psm_is_run(s_r.state) || s_r.state == psm_pkg::PSM_WAKE_TMR
        || s_r.state == psm_pkg::PSM_STABILISE;
    assign first_timer_en = psm_is_run(s_r.state) || s_r.state == psm_pkg::PSM_WAKE_TMR;
    assign pc_hold = ~psm_is_run(s_r.state);
    assign take_vector = s_r.vec;
    assign resume_next = s_r.resume;
    assign wdt_irq_req = s_r.wd_irq;
    assign int_reset_req = s_r.rst_req;
    assign reg_rdata = s_r.rdata;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_pending_stays;
        psm_is_run(s_r.state) && stop_exec && irq_pending |=> psm_is_run(s_r.state) && !pc_hold;
    endproperty
    a_pending_stays: assert property (p_pending_stays) else $error("stop taken with irq pending");

    property p_mode_select;
        stop_taken |=> (s_r.state == psm_pkg::PSM_WAKE_TMR) == $past(s_r.ckctl[psm_pkg::CK_WAKE_BIT])
            && (s_r.state == psm_pkg::PSM_STOP)
            == ($past(s_r.ckctl[psm_pkg::CK_WAKE_BIT:psm_pkg::CK_RCWD_BIT]) == 2'b00);
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("wrong low power mode");

    property p_stop_frozen;
        s_r.state == psm_pkg::PSM_STOP |-> !main_osc_run && !cpu_clk_en && !prescaler_en && pc_hold;
    endproperty
    a_stop_frozen: assert property (p_stop_frozen) else $error("clock alive in stop");

    property p_stop_exit;
        s_r.state == psm_pkg::PSM_STOP && !ext_edge |=> s_r.state == psm_pkg::PSM_STOP;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("stop left without edge");

    property p_stab_start;
        s_r.state == psm_pkg::PSM_STOP && ext_edge |=> s_r.state == psm_pkg::PSM_STABILISE
            && s_r.bit_cnt == psm_pkg::BIT_START && !cpu_clk_en;
    endproperty
    a_stab_start: assert property (p_stab_start) else $error("stabilisation not started at zero");

    property p_wt_fast;
        s_r.state == psm_pkg::PSM_WAKE_TMR && first_timer_ovf |=> cpu_clk_en ##0 (take_vector ^ resume_next);
    endproperty
    a_wt_fast: assert property (p_wt_fast) else $error("wake timer exit delayed");

    property p_wt_units;
        s_r.state == psm_pkg::PSM_WAKE_TMR |-> main_osc_run && first_timer_en && prescaler_en && !cpu_clk_en;
    endproperty
    a_wt_units: assert property (p_wt_units) else $error("wake timer gating wrong");

    property p_vector_sel;
        s_r.state == psm_pkg::PSM_WAKE_TMR && ext_edge |=> take_vector == $past(int_master_en);
    endproperty
    a_vector_sel: assert property (p_vector_sel) else $error("vector choice wrong");

    property p_rc_osc;
        s_r.state == psm_pkg::PSM_RC_WATCHDOG |-> rc_osc_run && !main_osc_run && pc_hold;
    endproperty
    a_rc_osc: assert property (p_rc_osc) else $error("rc mode oscillators wrong");

    property p_wd_flag;
        $rose(s_r.wd_flag) |-> $past(wd_match) && $past(bit_ovf);
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag without match");

    property p_wd_reset;
        s_r.state == psm_pkg::PSM_RC_WATCHDOG && s_r.wd_flag && int_master_en
            && s_r.ckctl[psm_pkg::CK_WDRST_BIT] |=> int_reset_req ##1 !int_reset_req;
    endproperty
    a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset not raised");

endmodule : psm_ctrl
`default_nettype wire

// file: tb/psm_core_model.sv
// model of the core, interrupt logic and timers around the power saving controller
`timescale 1ns/1ps
`default_nettype none
module psm_core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // bench commands
    input wire logic cmd_stop,
    input wire logic cmd_irq,
    input wire logic cmd_ovf,
    // controller status
    input wire logic pc_hold,
    input wire logic rc_osc_run,
    // towards the controller
    output logic stop_exec,
    output logic irq_pending,
    output logic first_timer_ovf,
    output logic rc_osc_clk
);
    logic [1:0] rc_div_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stop_exec <= 1'b0;
            irq_pending <= 1'b0;
            first_timer_ovf <= 1'b0;
            rc_osc_clk <= 1'b0;
            rc_div_r <= 2'h0;
        end else begin
            // one stop pulse, none while the core is parked
            stop_exec <= cmd_stop & ~stop_exec & ~pc_hold;
            // flags stay clear unless a test asks for one
            irq_pending <= cmd_irq;
            // overflow only when the bench orders it, one cycle later
            first_timer_ovf <= cmd_ovf;
            // rc clock of 8 cycles, standing low while disabled
            rc_div_r <= rc_osc_run ? rc_div_r + 2'h1 : 2'h0;
            if (!rc_osc_run) begin
                rc_osc_clk <= 1'b0;
            end else if (rc_div_r == 2'h3) begin
                rc_osc_clk <= ~rc_osc_clk;
            end
        end
    end
endmodule : psm_core_model
`default_nettype wire

// file: tb/power_saving_mode_control_test.sv
// self-checking bench of the power saving mode controller
`timescale 1ns/1ps
`default_nettype none
module power_saving_mode_control_test;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic stop_exec, irq_pending, first_timer_ovf, rc_osc_clk;
    logic int_master_en = 1'b0;
    logic watchdog_irq_enable = 1'b0;
    logic ext_irq_zero = 1'b0;
    logic ext_irq_one = 1'b0;
    logic cmd_stop = 1'b0;
    logic cmd_irq = 1'b0;
    logic cmd_ovf = 1'b0;
    logic main_osc_run, rc_osc_run, cpu_clk_en, prescaler_en, first_timer_en, presc_2048_tick, pc_hold;
    logic take_vector, resume_next, wdt_irq_req, int_reset_req;
    int num_errors = 0;
    int n_tests = 0;

    always #5 clk_sys = ~clk_sys;

    psm_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_exec(stop_exec),
        .irq_pending(irq_pending), .int_master_en(int_master_en), .watchdog_irq_enable(watchdog_irq_enable),
        .first_timer_ovf(first_timer_ovf), .ext_irq_zero(ext_irq_zero), .ext_irq_one(ext_irq_one),
        .rc_osc_clk(rc_osc_clk), .main_osc_run(main_osc_run), .rc_osc_run(rc_osc_run),
        .cpu_clk_en(cpu_clk_en), .prescaler_en(prescaler_en), .first_timer_en(first_timer_en),
        .presc_2048_tick(presc_2048_tick), .pc_hold(pc_hold), .take_vector(take_vector),
        .resume_next(resume_next), .wdt_irq_req(wdt_irq_req), .int_reset_req(int_reset_req));

    psm_core_model partner (.clk_sys(clk_sys), .rstn(rstn), .cmd_stop(cmd_stop), .cmd_irq(cmd_irq),
        .cmd_ovf(cmd_ovf), .pc_hold(pc_hold), .rc_osc_run(rc_osc_run), .stop_exec(stop_exec),
        .irq_pending(irq_pending), .first_timer_ovf(first_timer_ovf), .rc_osc_clk(rc_osc_clk));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata & mask);
    endtask : reg_check

    // {main osc, rc osc, cpu clock, prescaler, first timer, pc hold} per state
    function automatic logic [7:0] gate_exp(input logic [2:0] st);
        case (st)
            3'h1: gate_exp = 8'h01;
            3'h2: gate_exp = 8'h27;
            3'h3: gate_exp = 8'h11;
            default: gate_exp = 8'h2E;
        endcase
    endfunction : gate_exp

    task automatic gate_check(input logic [2:0] st);
        chk("clock_gates", gate_exp(st), {2'h0, main_osc_run, rc_osc_run, cpu_clk_en, prescaler_en,
            first_timer_en, pc_hold});
    endtask : gate_check

    task automatic issue_stop;
        @(posedge clk_sys) cmd_stop <= 1'b1;
        @(posedge clk_sys) cmd_stop <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : issue_stop

    task automatic wait_result(input logic [3:0] exp, input int mn, input int mx);
        int cnt;
        logic [3:0] got;
        cnt = 0;
        got = 4'h0;
        while (got == 4'h0 && cnt < mx) begin
            @(posedge clk_sys);
            #1;
            cnt++;
            got = {take_vector, resume_next, wdt_irq_req, int_reset_req};
        end
        chk("wake_result", {4'h0, exp}, {4'h0, got});
        chk("wake_delay_ok", 8'h01, {7'h0, cnt >= mn});
        gate_check(3'h0);
    endtask : wait_result

    // ev: 0 timer overflow, 1 pin zero, 2 pin one, 3 watchdog
    task automatic scen(input logic [7:0] ck, input logic ime, input logic wde, input int ev,
        input logic [2:0] st, input logic [3:0] vec, input int mn, input int mx);
        int cnt;
        reg_write(psm_pkg::ADDR_WDCMP, 8'h81);
        reg_write(psm_pkg::ADDR_STAT, 8'h01);
        reg_write(psm_pkg::ADDR_CKCTL, ck);
        int_master_en <= ime;
        watchdog_irq_enable <= wde;
        issue_stop();
        gate_check(st);
        reg_check(psm_pkg::ADDR_STAT, 8'h0E, {4'h0, st, 1'b0});
        if (ev == 0) begin
            cnt = 0;
            while (presc_2048_tick !== 1'b1 && cnt < 2100) begin
                @(posedge clk_sys);
                #1;
                cnt++;
            end
            chk("slow_tick_seen", 8'h01, {7'h0, presc_2048_tick === 1'b1});
            @(posedge clk_sys) cmd_ovf <= 1'b1;
            @(posedge clk_sys) cmd_ovf <= 1'b0;
        end else if (ev < 3) begin
            if (st == 3'h1) begin
                @(posedge clk_sys) cmd_ovf <= 1'b1;
                @(posedge clk_sys) cmd_ovf <= 1'b0;
                repeat (3) @(posedge clk_sys);
                reg_check(psm_pkg::ADDR_STAT, 8'h0E, 8'h02);
            end
            @(posedge clk_sys);
            ext_irq_zero <= (ev == 1);
            ext_irq_one <= (ev == 2);
        end
        wait_result(vec, mn, mx);
        ext_irq_zero <= 1'b0;
        ext_irq_one <= 1'b0;
        $display("test done: mode %h event %0d", ck, ev);
    endtask : scen

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_check(psm_pkg::ADDR_CKCTL, 8'hFF, 8'h00);
        reg_check(psm_pkg::ADDR_WDCMP, 8'hFF, 8'h7F);
        reg_check(psm_pkg::ADDR_STAT, 8'hFF, 8'h00);
        reg_write(3'h5, 8'hA5);
        reg_check(3'h5, 8'hFF, 8'h00);
        reg_write(psm_pkg::ADDR_WDCMP, 8'h81);
        reg_check(psm_pkg::ADDR_WDCMP, 8'hFF, 8'h01);
        gate_check(3'h0);
        $display("test done: registers after reset");
        reg_write(psm_pkg::ADDR_CKCTL, 8'h00);
        cmd_irq <= 1'b1;
        issue_stop();
        gate_check(3'h0);
        reg_check(psm_pkg::ADDR_STAT, 8'h0E, 8'h00);
        cmd_irq <= 1'b0;
        $display("test done: stop with pending flag");
        reg_write(psm_pkg::ADDR_CKCTL, 8'h07);
        issue_stop();
        gate_check(3'h1);
        @(posedge clk_sys) rstn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_check(psm_pkg::ADDR_CKCTL, 8'hFF, 8'h00);
        gate_check(3'h0);
        $display("test done: stop left by reset");
        scen(8'h40, 1'b1, 1'b0, 0, 3'h2, 4'h8, 1, 5);
        scen(8'h60, 1'b0, 1'b0, 2, 3'h2, 4'h4, 1, 8);
        scen(8'h00, 1'b1, 1'b0, 1, 3'h1, 4'h8, 4000, 4200);
        scen(8'h00, 1'b0, 1'b0, 2, 3'h1, 4'h4, 4000, 4200);
        scen(8'h20, 1'b0, 1'b0, 1, 3'h3, 4'h4, 4000, 4200);
        scen(8'h30, 1'b1, 1'b0, 3, 3'h3, 4'h1, 1, 4400);
        scen(8'h20, 1'b1, 1'b1, 3, 3'h3, 4'hA, 4000, 8800);
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule : power_saving_mode_control_test
`default_nettype wire
